// [rtl/pat_pkg.sv]
// Shared constants and types of the paged address translator.
`default_nettype none
package pat_pkg;
   // Address and entry geometry.
   localparam int VA_W = 64;
   localparam int PA_W = 56;
   localparam int PPN_W = 44;
   localparam int OFF_W = 12;
   localparam int IDX_W = 9;
   localparam int VPN_W = 36;
   localparam int PTE_W = 64;
   localparam int ENTRY_SIZE_LOG = 3;
   localparam int LVL_W = 2;
   // Level counts of the two schemes.
   localparam int LEVELS_THREE = 3;
   localparam int LEVELS_FOUR = 4;
   // Highest significant virtual address bit of each scheme.
   localparam int VA_TOP_THREE = 38;
   localparam int VA_TOP_FOUR = 47;
   // Entry flag positions and field layout.
   localparam int PTE_V = 0;
   localparam int PTE_R = 1;
   localparam int PTE_W_BIT = 2;
   localparam int PTE_X = 3;
   localparam int PTE_U = 4;
   localparam int PTE_G = 5;
   localparam int PTE_A = 6;
   localparam int PTE_D = 7;
   localparam int PTE_SW_LO = 8;
   localparam int PTE_PPN_LO = 10;
   localparam int PTE_RSV_LO = 54;
   // Register map, byte addresses.
   localparam int REG_AW = 8;
   localparam logic [7:0] REG_ROOT = 8'h00;
   localparam logic [7:0] REG_CTRL = 8'h08;
   localparam logic [7:0] REG_STAT = 8'h10;
   localparam logic [7:0] REG_FVA = 8'h18;
   // Root register fields.
   localparam int ROOT_MODE_LO = 60;
   localparam int MODE_W = 4;
   localparam logic [3:0] MODE_BARE = 4'h0;
   localparam logic [3:0] MODE_THREE_LEVEL_PAGING = 4'h8;
   localparam logic [3:0] MODE_FOUR_LEVEL_PAGING = 4'h9;
   // Control and status fields.
   localparam int CTRL_AD_UPDATE = 0;
   localparam int CNT_W = 16;
   localparam int STAT_BUSY = 16;
   // Kind of access being translated.
   typedef enum logic [1:0] {PAT_ACC_FETCH, PAT_ACC_LOAD, PAT_ACC_STORE} pat_acc_type;
   // Translation request from the hart.
   typedef struct packed {
      logic [63:0] va;
      pat_acc_type acc;
   } pat_req_type;
   // Translation answer to the hart.
   typedef struct packed {
      logic [55:0] pa;
      logic fault;
      pat_acc_type acc;
   } pat_rsp_type;
   // Table access towards the memory system.
   typedef struct packed {
      logic [55:0] addr;
      logic we;
      logic [63:0] wdata;
      logic lock;
   } pat_mem_type;
endpackage : pat_pkg
`default_nettype wire

// [rtl/pat_leaf.sv]
// Entry evaluation: validity, leaf test, permissions, alignment and physical page.
`default_nettype none
`timescale 1ns/1ps
module pat_leaf (
   // Entry under test and walk position.
   input wire logic [63:0] pte,
   input wire logic [1:0] lvl,
   input wire logic [63:0] va,
   input wire pat_pkg::pat_acc_type acc,
   // Verdicts.
   output logic bad,
   output logic leaf,
   output logic deny,
   output logic misal,
   output logic need_ad,
   // Translated page number and entry with flags set.
   output logic [43:0] ppn,
   output logic [63:0] upd_pte
);
   logic [43:0] pte_ppn; // Page number held in the entry.
   logic [43:0] mask; // Low page-number bits that the virtual address supplies.

   // Pure combinational judgement; the software field and global flag are ignored here.
   always_comb begin
      pte_ppn = pte[pat_pkg::PTE_PPN_LO +: pat_pkg::PPN_W];
      mask = (44'h1 << (pat_pkg::IDX_W * int'(lvl))) - 44'h1;
      // Invalid, or write without read, is a reserved encoding.
      bad = !pte[pat_pkg::PTE_V] || (!pte[pat_pkg::PTE_R] && pte[pat_pkg::PTE_W_BIT]);
      leaf = pte[pat_pkg::PTE_R] || pte[pat_pkg::PTE_X];
      // Each access kind needs its own permission flag.
      deny = ((acc == pat_pkg::PAT_ACC_FETCH) && !pte[pat_pkg::PTE_X])
         || ((acc == pat_pkg::PAT_ACC_LOAD) && !pte[pat_pkg::PTE_R])
         || ((acc == pat_pkg::PAT_ACC_STORE) && !pte[pat_pkg::PTE_W_BIT]);
      // A superpage needs its low page-number slices clear.
      misal = |(pte_ppn & mask);
      need_ad = !pte[pat_pkg::PTE_A] || ((acc == pat_pkg::PAT_ACC_STORE) && !pte[pat_pkg::PTE_D]);
      // Low slices from the virtual page number, upper ones from the entry.
      ppn = (pte_ppn & ~mask) | (pat_pkg::PPN_W'(va[pat_pkg::OFF_W +: pat_pkg::VPN_W]) & mask);
      upd_pte = pte;
      upd_pte[pat_pkg::PTE_A] = 1'b1;
      if (acc == pat_pkg::PAT_ACC_STORE) begin
         upd_pte[pat_pkg::PTE_D] = 1'b1;
      end
   end
endmodule : pat_leaf
`default_nettype wire

// [rtl/pat_regs.sv]
// Register file: translation root, control and fault status.
`default_nettype none
`timescale 1ns/1ps
module pat_regs (
   // Clock and reset.
   input wire logic clk_sys,
   input wire logic nrst,
   // Register port.
   input wire logic [7:0] reg_addr,
   input wire logic [63:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [63:0] reg_rdata,
   // State from the walker.
   input wire logic busy,
   input wire logic fault_evt,
   input wire logic [63:0] fault_va,
   // Settings to the walker.
   output logic [3:0] root_mode,
   output logic [43:0] root_ppn,
   output logic ad_update
);
   logic [3:0] mode_q, mode_d; // Scheme selector.
   logic [43:0] ppn_q, ppn_d; // Top table page number.
   logic adu_q, adu_d; // Set flags in memory instead of faulting.
   logic [15:0] cnt_q, cnt_d; // Faults seen, saturating.
   logic [63:0] fva_q, fva_d; // Address of the latest fault.
   logic [63:0] rd_q, rd_d; // Read data, valid one cycle after the strobe.

   // Next values; a fault event and a write in one cycle both take effect.
   always_comb begin
      mode_d = mode_q;
      ppn_d = ppn_q;
      adu_d = adu_q;
      cnt_d = cnt_q;
      fva_d = fva_q;
      rd_d = 64'h0000_0000_0000_0000;
      if (reg_wr) begin
         if (reg_addr == pat_pkg::REG_ROOT) begin
            mode_d = reg_wdata[pat_pkg::ROOT_MODE_LO +: pat_pkg::MODE_W];
            ppn_d = reg_wdata[pat_pkg::PPN_W-1:0];
         end else if (reg_addr == pat_pkg::REG_CTRL) begin
            adu_d = reg_wdata[pat_pkg::CTRL_AD_UPDATE];
         end else if (reg_addr == pat_pkg::REG_STAT) begin
            // Writing the status word clears the counter.
            cnt_d = 16'h0000;
         end
      end
      // A fault in the same cycle as a clear is counted after the clear, leaving one.
      if (fault_evt) begin
         fva_d = fault_va;
         if (cnt_d != 16'hffff) begin
            cnt_d = cnt_d + 16'h0001;
         end
      end
      // Unmapped addresses read as zero.
      if (reg_rd) begin
         if (reg_addr == pat_pkg::REG_ROOT) begin
            rd_d[pat_pkg::ROOT_MODE_LO +: pat_pkg::MODE_W] = mode_q;
            rd_d[pat_pkg::PPN_W-1:0] = ppn_q;
         end else if (reg_addr == pat_pkg::REG_CTRL) begin
            rd_d[pat_pkg::CTRL_AD_UPDATE] = adu_q;
         end else if (reg_addr == pat_pkg::REG_STAT) begin
            rd_d[pat_pkg::CNT_W-1:0] = cnt_q;
            rd_d[pat_pkg::STAT_BUSY] = busy;
         end else if (reg_addr == pat_pkg::REG_FVA) begin
            rd_d = fva_q;
         end
      end
   end

   // Registers only; reset leaves translation off.
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         mode_q <= pat_pkg::MODE_BARE;
         ppn_q <= 44'h000_0000_0000;
         adu_q <= 1'b0;
         cnt_q <= 16'h0000;
         fva_q <= 64'h0000_0000_0000_0000;
         rd_q <= 64'h0000_0000_0000_0000;
      end else begin
         mode_q <= mode_d;
         ppn_q <= ppn_d;
         adu_q <= adu_d;
         cnt_q <= cnt_d;
         fva_q <= fva_d;
         rd_q <= rd_d;
      end
   end

   assign reg_rdata = rd_q;
   assign root_mode = mode_q;
   assign root_ppn = ppn_q;
   assign ad_update = adu_q;
endmodule : pat_regs
`default_nettype wire

// [rtl/pat_walker.sv]
// Top level: table walker and address translator for the paged schemes.
//
// How it works
// - Three-level: bits 63..39 must copy bit 38.
// - Three-level maps 27-bit page to 44-bit page.
// - Three-level uses 4 KiB pages, 39-bit space.
// - Tables: one page, 512 entries, 9-bit index.
// - Top table page comes from root register.
// - Entry layout: reserved, page slices, flags.
// - Misaligned superpage leaf raises a page fault.
// - Three-level walk: 3 levels, 8-byte entries.
// - Four-level support implies three-level support.
// - Four-level: bits 63..48 must copy bit 47.
// - Four-level maps 36-bit page, offset untouched.
// - Four-level superpages must be naturally aligned.
// - Four-level walk: 4 levels, 8-byte entries.
// - Invalid or write-only entry stops with fault.
// - Read or execute marks leaf; else descend.
// - Missing accessed or dirty: fault or set.
// - Superpage low slices come from virtual page.
`default_nettype none
`timescale 1ns/1ps
module pat_walker (
   // Clock and reset.
   input wire logic clk_sys,
   input wire logic nrst,
   // Register port.
   input wire logic [7:0] reg_addr,
   input wire logic [63:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [63:0] reg_rdata,
   // Translation requests from the hart.
   input wire logic req_valid,
   output logic req_ready,
   input wire pat_pkg::pat_req_type req,
   // Translation answers to the hart.
   output logic rsp_valid,
   output pat_pkg::pat_rsp_type rsp,
   // Table accesses to the memory system.
   output logic mem_req_valid,
   input wire logic mem_req_ready,
   output pat_pkg::pat_mem_type mem_req,
   input wire logic mem_rsp_valid,
   input wire logic [63:0] mem_rdata
);
   // Walk phases.
   typedef enum logic [2:0] {ST_IDLE, ST_ISSUE, ST_WAIT, ST_WRITE, ST_WACK} pat_state_type;

   pat_state_type st_q, st_d; // Walk phase.
   logic [63:0] va_q, va_d; // Address being translated.
   pat_pkg::pat_acc_type acc_q, acc_d; // Its access kind.
   logic [1:0] lvl_q, lvl_d; // Current table level.
   logic [55:0] ptea_q, ptea_d; // Address of the entry being read.
   logic [63:0] pte_q, pte_d; // Entry to write back.
   logic [43:0] ppn_q, ppn_d; // Result page kept across a write-back.
   logic rspv_q, rspv_d; // Answer strobe.
   pat_pkg::pat_rsp_type rsp_q, rsp_d; // Answer contents.

   logic [3:0] root_mode; // Scheme selector.
   logic [43:0] root_ppn; // Top table page.
   logic ad_update; // Set flags instead of faulting.
   logic four; // Four-level scheme chosen.
   logic paging; // Either scheme chosen.
   logic noncanon; // Upper address bits are not copies.
   logic start; // A walk begins this cycle.
   logic bad, leaf, deny, misal, need_ad; // Verdicts on the returned entry.
   logic [43:0] leaf_ppn; // Page that the entry translates to.
   logic [63:0] upd_pte; // Entry with flags set.

   // Register file.
   pat_regs u_regs (
      .clk_sys(clk_sys),
      .nrst(nrst),
      .reg_addr(reg_addr),
      .reg_wdata(reg_wdata),
      .reg_wr(reg_wr),
      .reg_rd(reg_rd),
      .reg_rdata(reg_rdata),
      .busy(st_q != ST_IDLE),
      .fault_evt(rspv_q && rsp_q.fault),
      .fault_va(va_q),
      .root_mode(root_mode),
      .root_ppn(root_ppn),
      .ad_update(ad_update)
   );

   // Judge the entry as it arrives from memory.
   pat_leaf u_leaf (
      .pte(mem_rdata),
      .lvl(lvl_q),
      .va(va_q),
      .acc(acc_q),
      .bad(bad),
      .leaf(leaf),
      .deny(deny),
      .misal(misal),
      .need_ad(need_ad),
      .ppn(leaf_ppn),
      .upd_pte(upd_pte)
   );

   // Scheme choice; both schemes are always present, other codes mean no translation.
   assign four = (root_mode == pat_pkg::MODE_FOUR_LEVEL_PAGING);
   assign paging = four || (root_mode == pat_pkg::MODE_THREE_LEVEL_PAGING);

   // Canonical check per scheme.
   always_comb begin
      if (four) begin
         noncanon = req.va[pat_pkg::VA_W-1:pat_pkg::VA_TOP_FOUR+1]
            != {(pat_pkg::VA_W-1-pat_pkg::VA_TOP_FOUR){req.va[pat_pkg::VA_TOP_FOUR]}};
      end else begin
         noncanon = req.va[pat_pkg::VA_W-1:pat_pkg::VA_TOP_THREE+1]
            != {(pat_pkg::VA_W-1-pat_pkg::VA_TOP_THREE){req.va[pat_pkg::VA_TOP_THREE]}};
      end
   end

   // Handshakes are combinational from the phase.
   assign req_ready = (st_q == ST_IDLE);
   assign mem_req_valid = (st_q == ST_ISSUE) || (st_q == ST_WRITE);
   assign start = req_valid && req_ready && paging && !noncanon;

   // Next-state logic of the walk.
   always_comb begin
      st_d = st_q;
      va_d = va_q;
      acc_d = acc_q;
      lvl_d = lvl_q;
      ptea_d = ptea_q;
      pte_d = pte_q;
      ppn_d = ppn_q;
      rspv_d = 1'b0;
      rsp_d = rsp_q;
      case (st_q)
         ST_IDLE: begin
            if (req_valid) begin
               va_d = req.va;
               acc_d = req.acc;
               rsp_d.acc = req.acc;
               rsp_d.fault = 1'b0;
               rsp_d.pa = req.va[pat_pkg::PA_W-1:0];
               if (!paging) begin
                  // No translation: the address passes straight through.
                  rspv_d = 1'b1;
               end else if (noncanon) begin
                  rsp_d.fault = 1'b1;
                  rspv_d = 1'b1;
               end else begin
                  // Start at the top level from the root page.
                  if (four) begin
                     lvl_d = pat_pkg::LVL_W'(pat_pkg::LEVELS_FOUR - 1);
                  end else begin
                     lvl_d = pat_pkg::LVL_W'(pat_pkg::LEVELS_THREE - 1);
                  end
                  ptea_d = {root_ppn, req.va[pat_pkg::OFF_W + pat_pkg::IDX_W * int'(lvl_d) +: pat_pkg::IDX_W],
                     {pat_pkg::ENTRY_SIZE_LOG{1'b0}}};
                  st_d = ST_ISSUE;
               end
            end
         end
         ST_ISSUE: begin
            if (mem_req_ready) begin
               st_d = ST_WAIT;
            end
         end
         ST_WAIT: begin
            // Nothing is judged until the entry returns.
            if (mem_rsp_valid) begin
               if (bad) begin
                  rsp_d.fault = 1'b1;
                  rspv_d = 1'b1;
                  st_d = ST_IDLE;
               end else if (!leaf) begin
                  if (lvl_q == 2'h0) begin
                     // Pointer at the last level: out of levels.
                     rsp_d.fault = 1'b1;
                     rspv_d = 1'b1;
                     st_d = ST_IDLE;
                  end else begin
                     lvl_d = lvl_q - 2'h1;
                     ptea_d = {mem_rdata[pat_pkg::PTE_PPN_LO +: pat_pkg::PPN_W],
                        va_q[pat_pkg::OFF_W + pat_pkg::IDX_W * int'(lvl_d) +: pat_pkg::IDX_W],
                        {pat_pkg::ENTRY_SIZE_LOG{1'b0}}};
                     st_d = ST_ISSUE;
                  end
               end else if (deny || misal) begin
                  rsp_d.fault = 1'b1;
                  rspv_d = 1'b1;
                  st_d = ST_IDLE;
               end else if (need_ad && !ad_update) begin
                  rsp_d.fault = 1'b1;
                  rspv_d = 1'b1;
                  st_d = ST_IDLE;
               end else if (need_ad) begin
                  // Bus stays locked from read to write, so the update is atomic.
                  pte_d = upd_pte;
                  ppn_d = leaf_ppn;
                  st_d = ST_WRITE;
               end else begin
                  rsp_d.pa = {leaf_ppn, va_q[pat_pkg::OFF_W-1:0]};
                  rspv_d = 1'b1;
                  st_d = ST_IDLE;
               end
            end
         end
         ST_WRITE: begin
            if (mem_req_ready) begin
               st_d = ST_WACK;
            end
         end
         ST_WACK: begin
            // The access is released only once the update is acknowledged.
            if (mem_rsp_valid) begin
               rsp_d.pa = {ppn_q, va_q[pat_pkg::OFF_W-1:0]};
               rspv_d = 1'b1;
               st_d = ST_IDLE;
            end
         end
         default: begin
            st_d = ST_IDLE;
         end
      endcase
   end

   // Walk registers.
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         st_q <= ST_IDLE;
         va_q <= 64'h0000_0000_0000_0000;
         acc_q <= pat_pkg::PAT_ACC_FETCH;
         lvl_q <= 2'h0;
         ptea_q <= 56'h00_0000_0000_0000;
         pte_q <= 64'h0000_0000_0000_0000;
         ppn_q <= 44'h000_0000_0000;
         rspv_q <= 1'b0;
         rsp_q <= '0;
      end else begin
         st_q <= st_d;
         va_q <= va_d;
         acc_q <= acc_d;
         lvl_q <= lvl_d;
         ptea_q <= ptea_d;
         pte_q <= pte_d;
         ppn_q <= ppn_d;
         rspv_q <= rspv_d;
         rsp_q <= rsp_d;
      end
   end

   // Outputs come straight from registers, write and lock decoded from the phase; the lock covers the whole walk.
   assign rsp_valid = rspv_q;
   assign rsp = rsp_q;
   assign mem_req.addr = ptea_q;
   assign mem_req.we = (st_q == ST_WRITE);
   assign mem_req.wdata = pte_q;
   assign mem_req.lock = (st_q != ST_IDLE);

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!nrst);

   // An entry arriving during a walk.
   sequence s_pte_in;
      (st_q == ST_WAIT) && mem_rsp_valid;
   endsequence
   // A valid pointer entry with levels left.
   sequence s_descend;
      s_pte_in ##0 (!bad && !leaf && (lvl_q != 2'h0));
   endsequence

   a_mem_aligned: assert property (mem_req_valid |-> (mem_req.addr[2:0] == 3'h0) && mem_req.lock)
      else $error("table access not aligned or not locked");
   a_root_first: assert property (start |=> mem_req_valid && !mem_req.we
      && (mem_req.addr[55:12] == $past(root_ppn)))
      else $error("walk did not start at the root table");
   a_top_index: assert property (start && four |=> mem_req.addr[11:3] == $past(req.va[47:39]))
      else $error("wrong top index for four levels");
   a_canon_fault: assert property (req_valid && req_ready && paging && noncanon |=> rsp_valid && rsp.fault)
      else $error("noncanonical address not faulted");
   a_invalid_stop: assert property (s_pte_in ##0 bad |=> rsp_valid && rsp.fault && !mem_req_valid)
      else $error("invalid entry did not stop the walk");
   a_next_level: assert property (s_descend |=> mem_req_valid
      && (mem_req.addr[55:12] == $past(mem_rdata[53:10])) && (lvl_q == $past(lvl_q) - 2'h1))
      else $error("descent used wrong table or level");
   a_out_levels: assert property (s_pte_in ##0 (!bad && !leaf && (lvl_q == 2'h0)) |=> rsp_valid && rsp.fault)
      else $error("pointer at last level not faulted");
   a_superpage_align: assert property (s_pte_in ##0 (!bad && leaf && misal) |=> rsp_valid && rsp.fault)
      else $error("misaligned superpage not faulted");
   a_flag_update: assert property (s_pte_in ##0 (!bad && leaf && !deny && !misal && need_ad && ad_update)
      |=> mem_req_valid && mem_req.we && mem_req.wdata[pat_pkg::PTE_A]
      && (mem_req.wdata[pat_pkg::PTE_D] || (acc_q != pat_pkg::PAT_ACC_STORE)))
      else $error("missing flags not written back");
   a_offset_pass: assert property (rsp_valid && !rsp.fault |-> rsp.pa[11:0] == va_q[11:0])
      else $error("page offset altered");
   a_fault_tag: assert property (rsp_valid |-> rsp.acc == acc_q)
      else $error("answer carries wrong access kind");
endmodule : pat_walker
`default_nettype wire

// [bench/pat_mem_model.sv]
// Memory system model that serves and updates table entries for the walker.
`timescale 1ns/1ps
`default_nettype none
module pat_mem_model (
   // Clock, reset and pacing.
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic slow,
   // Table access port.
   input wire logic mem_req_valid,
   output logic mem_req_ready,
   input wire pat_pkg::pat_mem_type mem_req,
   output logic mem_rsp_valid = 1'b0,
   output logic [63:0] mem_rdata = 64'h0,
   output int n_unaligned = 0
);
   logic [63:0] mem [logic [55:0]]; // Sparse entry store; absent words read as zero.
   pat_pkg::pat_mem_type cap; // Access being served.
   logic busy = 1'b0; // An access is in flight.
   int gap = 0; // Wait states left in slow mode.
   // Ready only while idle, so one access is in flight at a time.
   assign mem_req_ready = (nrst === 1'b1) && !busy;
   // Data lines toggle outside the answer, so a stale entry never looks fresh.
   always @(posedge clk_sys) begin
      mem_rsp_valid <= 1'b0;
      mem_rdata <= ~mem_rdata;
      if (nrst !== 1'b1) begin
         busy <= 1'b0;
      end else if (!busy && mem_req_valid) begin
         cap <= mem_req;
         busy <= 1'b1;
         gap <= slow ? 4 : 0;
         n_unaligned <= n_unaligned + int'(mem_req.addr[2:0] != 3'h0);
      end else if (busy && gap > 0) begin
         gap <= gap - 1;
      end else if (busy) begin
         busy <= 1'b0;
         mem_rsp_valid <= 1'b1;
         if (cap.we) begin
            mem[cap.addr] = cap.wdata;
         end
         mem_rdata <= mem.exists(cap.addr) ? mem[cap.addr] : 64'h0;
      end
   end
endmodule : pat_mem_model
`default_nettype wire

// [bench/pat_walker_tb.sv]
// Self-checking bench of the walker against a memory model.
`timescale 1ns/1ps
`default_nettype none
module pat_walker_tb;
   localparam pat_pkg::pat_acc_type FE = pat_pkg::PAT_ACC_FETCH;
   localparam pat_pkg::pat_acc_type LD = pat_pkg::PAT_ACC_LOAD;
   localparam pat_pkg::pat_acc_type ST = pat_pkg::PAT_ACC_STORE;
   // Case: mode, address, access, fault expected, physical address expected.
   typedef struct packed {logic [3:0] m; logic [63:0] va; pat_pkg::pat_acc_type k; logic f; logic [55:0] pa;} pat_row_type;
   logic clk_sys;
   logic nrst = 1'b0, slow = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, req_valid = 1'b0;
   logic req_ready, rsp_valid, mem_req_valid, mem_req_ready, mem_rsp_valid;
   logic [7:0] reg_addr = 8'h00;
   logic [63:0] reg_wdata = 64'h0, reg_rdata, mem_rdata;
   pat_pkg::pat_req_type req = '0;
   pat_pkg::pat_rsp_type rsp;
   pat_pkg::pat_mem_type mem_req;
   int miscompares = 0, n_tests = 0, n_unaligned;
   int nf = 0; // Faults the status counter should hold.
   logic [63:0] fva = 64'h0; // Address of the latest fault.
   // Entries placed by software with the top bits clear; unlisted words read as invalid.
   logic [55:0] ea [11] = '{56'h10_0008, 56'h10_1008, 56'h10_2008, 56'h10_1010, 56'h10_1018, 56'h10_1020,
      56'h10_1028, 56'h10_2010, 56'h10_0018, 56'h10_2018, 56'h10_3038};
   logic [63:0] ed [11] = '{64'h4_0401, 64'h4_0801, 64'h48D_14CF, 64'h8_00CF, 64'h8_04CF, 64'hC_00C5,
      64'h10_00C9, 64'h4_0C01, 64'h1000_00CF, 64'h14_004F, 64'h1D_DCCF};
   // Three-level leaves at every level and each fault kind, then four-level, then bare.
   pat_row_type rows [17] = '{
      '{4'h8, 64'h4020_1abc, LD, 1'b0, 56'h1234_5abc},
      '{4'h8, 64'h4040_5123, ST, 1'b0, 56'h20_5123},
      '{4'h8, 64'h4060_0000, LD, 1'b1, 56'h0},
      '{4'h8, 64'h8000_0000, LD, 1'b1, 56'h0},
      '{4'h8, 64'h4080_0000, ST, 1'b1, 56'h0},
      '{4'h8, 64'h40A0_0000, LD, 1'b1, 56'h0},
      '{4'h8, 64'h40A0_3456, FE, 1'b0, 56'h40_3456},
      '{4'h8, 64'h4020_2000, LD, 1'b1, 56'h0},
      '{4'h8, 64'hD234_5678, LD, 1'b0, 56'h5234_5678},
      '{4'h8, 64'h4020_3010, ST, 1'b1, 56'h0},
      '{4'h8, 64'h4020_3010, LD, 1'b0, 56'h50_0010},
      '{4'h8, 64'h80_0000_0000, LD, 1'b1, 56'h0},
      '{4'h9, 64'h80_4040_7456, FE, 1'b0, 56'h77_7456},
      '{4'h9, 64'h80_4020_0000, LD, 1'b1, 56'h0},
      '{4'h9, 64'h80_8000_0000, LD, 1'b1, 56'h0},
      '{4'h9, 64'h1_0000_0000_0000, LD, 1'b1, 56'h0},
      '{4'h0, 64'h1234_5678_9abc_def0, ST, 1'b0, 56'h34_5678_9abc_def0}};
   pat_walker dut (.clk_sys(clk_sys), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .req_valid(req_valid), .req_ready(req_ready), .req(req),
      .rsp_valid(rsp_valid), .rsp(rsp), .mem_req_valid(mem_req_valid), .mem_req_ready(mem_req_ready),
      .mem_req(mem_req), .mem_rsp_valid(mem_rsp_valid), .mem_rdata(mem_rdata));
   pat_mem_model mdl (.clk_sys(clk_sys), .nrst(nrst), .slow(slow), .mem_req_valid(mem_req_valid),
      .mem_req_ready(mem_req_ready), .mem_req(mem_req), .mem_rsp_valid(mem_rsp_valid), .mem_rdata(mem_rdata),
      .n_unaligned(n_unaligned));
   // Counts every comparison and reports a mismatch at once.
   task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
      n_tests++;
      if (g !== e) begin
         miscompares++;
         $display("wrong value %s: expected %h, seen %h", nm, e, g);
      end
   endtask : chk
   // One write: a single strobe cycle.
   task automatic wr(input logic [7:0] a, input logic [63:0] d);
      @(posedge clk_sys);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask : wr
   // One read; the data stand only in the cycle after the strobe.
   task automatic rd(input logic [7:0] a, input logic [63:0] e, input string nm);
      @(posedge clk_sys);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      @(negedge clk_sys);
      chk(nm, e, reg_rdata);
   endtask : rd
   // Picks the scheme, holds the request until taken, then checks the one-cycle answer.
   task automatic xl(input pat_row_type r);
      int n;
      wr(pat_pkg::REG_ROOT, {r.m, 16'h0000, 44'h100});
      @(posedge clk_sys);
      req_valid <= 1'b1;
      req <= '{va: r.va, acc: r.k};
      @(negedge clk_sys);
      for (n = 0; req_ready !== 1'b1 && n < 300; n++) @(negedge clk_sys);
      @(posedge clk_sys);
      req_valid <= 1'b0;
      @(negedge clk_sys);
      for (n = 0; rsp_valid !== 1'b1 && n < 300; n++) @(negedge clk_sys);
      chk("translation", {4'h0, 1'b1, r.f, r.k, r.f ? 56'h0 : r.pa},
         {4'h0, rsp_valid, rsp.fault, rsp.acc, rsp.fault ? 56'h0 : rsp.pa});
   endtask : xl
   // Prints the counts and the verdict, then ends the run.
   task automatic conclude;
      $display("comparisons %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : conclude
   initial begin
      clk_sys = 1'b0;
      forever #12.5 clk_sys = ~clk_sys;
   end
   // The whole run needs well under a thousand cycles; twenty thousand means a hang.
   initial begin
      #500000;
      miscompares++;
      conclude();
   end
   initial begin
      foreach (ea[i]) mdl.mem[ea[i]] = ed[i];
      repeat (16) @(posedge clk_sys);
      nrst <= 1'b1;
      rd(pat_pkg::REG_ROOT, 64'h0, "root");
      rd(pat_pkg::REG_CTRL, 64'h0, "control");
      rd(pat_pkg::REG_STAT, 64'h0, "status");
      rd(pat_pkg::REG_FVA, 64'h0, "fault address");
      rd(8'h20, 64'h0, "unmapped");
      $display("test reset done");
      // Prompt memory first, then wait states on every entry read.
      for (int p = 0; p < 2; p++) begin
         slow <= p[0];
         foreach (rows[i]) begin
            xl(rows[i]);
            if (rows[i].f) begin
               nf++;
               fva = rows[i].va;
            end
         end
         $display("test table pass %0d done", p);
      end
      rd(pat_pkg::REG_STAT, {48'h0, 16'(nf)}, "fault count");
      rd(pat_pkg::REG_FVA, fva, "fault address");
      wr(pat_pkg::REG_STAT, 64'h0);
      rd(pat_pkg::REG_STAT, 64'h0, "cleared count");
      $display("test status done");
      // With flag update on, a store sets the dirty flag in memory instead of faulting.
      wr(pat_pkg::REG_CTRL, 64'h1);
      xl('{4'h8, 64'h4020_3010, ST, 1'b0, 56'h50_0010});
      chk("entry after update", 64'h14_00CF, mdl.mem[56'h10_2018]);
      chk("unaligned accesses", 64'h0, 64'(n_unaligned));
      $display("test flag update done");
      // A slow walk is still in flight when the status word is read, so busy must show.
      @(posedge clk_sys);
      req_valid <= 1'b1;
      @(posedge clk_sys);
      req_valid <= 1'b0;
      rd(pat_pkg::REG_STAT, 64'h0000_0000_0001_0000, "busy");
      $display("test busy done");
      conclude();
   end
endmodule : pat_walker_tb
`default_nettype wire
